// file: inc/mtapt_consts.svh
/*
 offsets, field positions, reset values and limits of the position tracker.
 assumes inclusion by bare name from the package and the design modules.
*/
`ifndef MTAPT_CONSTS_SVH
`define MTAPT_CONSTS_SVH
`define MTAPT_A_BMASK   8'h00
`define MTAPT_A_THR     8'h04
`define MTAPT_A_RST     8'h08
`define MTAPT_A_OFS     8'h0c
`define MTAPT_A_ST      8'h10
`define MTAPT_A_TURNS   8'h14
`define MTAPT_A_CUR     8'h18
`define MTAPT_A_FCLR    8'h1c
`define MTAPT_A_STAT    8'h20
`define MTAPT_A_ISTS    8'h24
`define MTAPT_A_IMSK    8'h28
`define MTAPT_A_ABSLO   8'h2c
`define MTAPT_A_ABSHI   8'h30
`define MTAPT_THR_RST   8'h14
`define MTAPT_THR_MAX   32'h00000064
`define MTAPT_OFS_RST   32'h00000000
`define MTAPT_OFS_MIN   32'h80000001
`define MTAPT_OFS_MAX   32'h7ffffffe
`define MTAPT_MAG_MAX   24'h01ffff
`define MTAPT_OPT_MAX   24'h7fffff
`define MTAPT_LOW_MV    12'hc1c
`define MTAPT_EV_BFAIL  0
`define MTAPT_EV_UV     1
`define MTAPT_EV_LOW    2
`define MTAPT_EV_COMM   3
`define MTAPT_EV_W      4
`endif

// file: inc/mtapt_pkg.sv
/*
 types of the position tracker: bus and encoder carriers, state records.
 assumes the constants header is on the include path.
*/
`include "mtapt_consts.svh"
package mtapt_pkg;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } mtapt_bus_s;

   typedef struct packed {
      logic        valid;
      logic [22:0] pos;
      logic        chk_err;
      logic        optical;
      logic        uv;
      logic        connect;
      logic [11:0] mv;
   } mtapt_enc_s;

   typedef struct packed {
      logic                   bmask_set;
      logic                   bmask_act;
      logic [7:0]             thr;
      logic [31:0]            ofs;
      logic                   st_ok;
      logic [22:0]            st;
      logic [15:0]            turns;
      logic [31:0]            cur;
      logic                   bfail;
      logic                   uvflt;
      logic                   lowwarn;
      logic                   comm_prev;
      logic [`MTAPT_EV_W-1:0] ists;
      logic [`MTAPT_EV_W-1:0] imsk;
      logic                   irq;
      logic [31:0]            rdata;
   } mtapt_state_s;

   typedef struct packed {
      logic [7:0] cnt;
      logic       warn;
   } mtapt_cnt_s;
endpackage : mtapt_pkg

// file: src/mtapt_err_count.sv
/*
 saturating counter of encoder read/write check errors with threshold warning.
 assumes err and clr are one-cycle pulses synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mtapt_consts.svh"
module mtapt_err_count
   import mtapt_pkg::*;
(
   input  wire logic       clk,   // system clock
   input  wire logic       srst,  // synchronous reset
   input  wire logic       err,   // check error seen
   input  wire logic       clr,   // clear count and warning
   input  wire logic [7:0] thr,   // warning threshold, zero disables
   output var  logic [7:0] cnt,   // errors counted
   output var  logic       warn   // count above threshold
);
   mtapt_cnt_s c_q;
   mtapt_cnt_s c_d;

   always_comb begin
      c_d = c_q;
      if (clr) begin
         c_d.cnt = {7'h00, err};
      end else if (err && c_q.cnt != 8'hff) begin
         c_d.cnt = c_q.cnt + 8'h01; // RL12
      end
      c_d.warn = (thr != 8'h00) && (c_d.cnt > thr); // RL12
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         c_q <= '0;
      end else begin
         c_q <= c_d;
      end
   end

   assign cnt  = c_q.cnt;
   assign warn = c_q.warn;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_warn_zero_thr: assert property (thr == 8'h00 |=> !warn) // RL12
      else $error("warning raised with threshold zero");
   a_warn_over_thr: assert property (!clr && err && thr != 8'h00 && cnt == thr |=> warn) // RL12
      else $error("warning missing when count passes threshold");
endmodule : mtapt_err_count
`default_nettype wire

// file: src/mtapt_top.sv
/*
 multi-turn absolute position tracker: turns tracking, origin offset,
 battery faults, check error warning, register port and interrupt.
 assumes encoder samples and strobes are synchronous to clk and that
 pwr_up pulses once per power-up of the drive.
*/
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "mtapt_consts.svh"
// Notes on behaviour
// RL1: keep a 16-bit revolution count
// RL2: magnetic type: 17-bit single-turn position
// RL3: optical type: 23-bit single-turn position
// RL4: reset command clears turns, position, faults
// RL5: reset command loads position with offset
// RL6: signed offset, limited range, immediate effect
// RL7: single-turn position readable as 32 bits
// RL8: revolution count readable as 16 bits
// RL9: current position readable as 32 bits
// RL10: unmasked: report battery undervoltage and low
// RL11: mask set: suppress battery failure alarm
// RL12: count check errors, warn above threshold
// RL13: host must redo origin return after reset
// RL14: battery below 3.1 V raises warning
// RL15: battery fault held until clear or reset
// RL16: absolute position is turns over single-turn
// RL17: mask change acts after next power-up
module mtapt_top
   import mtapt_pkg::*;
(
   input  wire logic       clk,        // 125 MHz system clock
   input  wire logic       srst,       // synchronous reset
   input  wire logic       pwr_up,     // power-up pulse
   input  var  mtapt_bus_s bus,        // register port request
   input  var  mtapt_enc_s enc,        // encoder samples and battery state
   output var  logic [31:0] rd_data,   // read data, cycle after read strobe
   output var  logic       irq,        // interrupt level
   output var  logic       comm_warn,  // check error warning
   output var  logic       batt_fail,  // battery failure fault
   output var  logic       batt_low    // battery low warning
);
   mtapt_state_s s_q;
   mtapt_state_s s_d;

   logic                   rst_cmd;
   logic                   fclr;
   logic                   wr_ofs;
   logic                   ofs_ok;
   logic [7:0]             err_cnt;
   logic                   err_warn;
   logic [23:0]            res_max;
   logic [23:0]            pos_n;
   logic signed [24:0]     dl;
   logic signed [24:0]     hf;
   logic signed [24:0]     rs;
   logic [39:0]            abs_pos;
   logic [`MTAPT_EV_W-1:0] ev;
   logic [`MTAPT_EV_W-1:0] w1c;

   assign rst_cmd = bus.wr && bus.addr == `MTAPT_A_RST && bus.wdata[0];
   assign fclr    = bus.wr && bus.addr == `MTAPT_A_FCLR && bus.wdata[0];
   assign wr_ofs  = bus.wr && bus.addr == `MTAPT_A_OFS;
   // RL6: the two end codes of the 32-bit range are refused
   assign ofs_ok  = ($signed(bus.wdata) >= $signed(`MTAPT_OFS_MIN)) &&
                    ($signed(bus.wdata) <= $signed(`MTAPT_OFS_MAX));

   mtapt_err_count u_err (
      .clk  (clk),
      .srst (srst),
      .err  (enc.chk_err),
      .clr  (rst_cmd || fclr),
      .thr  (s_q.thr),
      .cnt  (err_cnt),
      .warn (err_warn)
   );

   always_comb begin
      s_d = s_q;
      ev  = '0;
      w1c = '0;
      res_max = enc.optical ? `MTAPT_OPT_MAX : `MTAPT_MAG_MAX; // RL2 RL3
      pos_n   = {1'b0, enc.pos} & res_max; // RL2 RL3
      hf = $signed({2'b00, res_max[23:1]});
      rs = $signed({1'b0, res_max}) + 25'sh0000001;
      dl = $signed({1'b0, pos_n}) - $signed({2'b00, s_q.st});

      // register writes
      if (bus.wr) begin
         unique case (bus.addr)
            `MTAPT_A_BMASK: begin
               s_d.bmask_set = bus.wdata[0];
            end
            `MTAPT_A_THR: begin
               if (bus.wdata <= `MTAPT_THR_MAX) begin
                  s_d.thr = bus.wdata[7:0]; // RL12
               end
            end
            `MTAPT_A_OFS: begin
               if (ofs_ok) begin
                  s_d.ofs = bus.wdata; // RL6
               end
            end
            `MTAPT_A_ISTS: begin
               w1c = bus.wdata[`MTAPT_EV_W-1:0];
            end
            `MTAPT_A_IMSK: begin
               s_d.imsk = bus.wdata[`MTAPT_EV_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // mask setting only becomes active at power-up
      if (pwr_up) begin
         s_d.bmask_act = s_q.bmask_set; // RL17
      end

      // single-turn tracking with revolution counting on wrap
      if (enc.valid) begin
         s_d.st    = pos_n[22:0];
         s_d.st_ok = 1'b1;
         if (s_q.st_ok) begin
            if (dl > hf) begin
               dl = dl - rs;
               s_d.turns = s_q.turns - 16'h0001; // RL1
            end else if (dl < -hf) begin
               dl = dl + rs;
               s_d.turns = s_q.turns + 16'h0001; // RL1
            end
            s_d.cur = s_q.cur + {{7{dl[24]}}, dl}; // RL9
         end
      end

      // reset command wins over tracking for the position data
      if (rst_cmd) begin
         s_d.turns = 16'h0000; // RL4
         s_d.cur   = s_q.ofs;  // RL5
      end

      // faults: clear first, then set so a new event is kept
      if (rst_cmd || fclr) begin
         s_d.bfail = 1'b0; // RL4 RL15
         s_d.uvflt = 1'b0; // RL4
      end
      if (enc.connect && !s_q.bmask_act) begin
         s_d.bfail = 1'b1; // RL15 RL11
         ev[`MTAPT_EV_BFAIL] = !s_q.bfail;
      end
      if (enc.uv && !s_q.bmask_act) begin
         s_d.uvflt = 1'b1; // RL10 RL11
         ev[`MTAPT_EV_UV] = !s_q.uvflt;
      end
      s_d.lowwarn = !s_q.bmask_act && (enc.mv < `MTAPT_LOW_MV); // RL14 RL10
      ev[`MTAPT_EV_LOW] = s_d.lowwarn && !s_q.lowwarn;
      s_d.comm_prev = err_warn;
      ev[`MTAPT_EV_COMM] = err_warn && !s_q.comm_prev;

      // sticky status, set wins over write-one-to-clear
      s_d.ists = (s_q.ists & ~w1c) | ev;
      s_d.irq  = |(s_d.ists & s_d.imsk);

      // absolute position: turns above the single-turn bits
      if (enc.optical) begin
         abs_pos = {1'b0, s_q.turns, s_q.st}; // RL16
      end else begin
         abs_pos = {7'h00, s_q.turns, s_q.st[16:0]}; // RL16
      end

      // read data
      s_d.rdata = 32'h00000000;
      if (bus.rd) begin
         unique case (bus.addr)
            `MTAPT_A_BMASK: s_d.rdata = {31'h0, s_q.bmask_set};
            `MTAPT_A_THR:   s_d.rdata = {24'h0, s_q.thr};
            `MTAPT_A_OFS:   s_d.rdata = s_q.ofs;
            `MTAPT_A_ST:    s_d.rdata = {9'h000, s_q.st}; // RL7
            `MTAPT_A_TURNS: s_d.rdata = {16'h0000, s_q.turns}; // RL8
            `MTAPT_A_CUR:   s_d.rdata = s_q.cur; // RL9
            `MTAPT_A_STAT:  s_d.rdata = {12'h000, err_cnt, 4'h0, enc.optical, s_q.bmask_act,
                                         2'b00, err_warn, s_q.lowwarn, s_q.uvflt, s_q.bfail};
            `MTAPT_A_ISTS:  s_d.rdata = {28'h0, s_q.ists};
            `MTAPT_A_IMSK:  s_d.rdata = {28'h0, s_q.imsk};
            `MTAPT_A_ABSLO: s_d.rdata = abs_pos[31:0]; // RL16
            `MTAPT_A_ABSHI: s_d.rdata = {24'h000000, abs_pos[39:32]}; // RL16
            default:        s_d.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_q     <= '0;
         s_q.thr <= `MTAPT_THR_RST;
         s_q.ofs <= `MTAPT_OFS_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_data   = s_q.rdata;
   assign irq       = s_q.irq;
   assign comm_warn = err_warn;
   assign batt_fail = s_q.bfail;
   assign batt_low  = s_q.lowwarn;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_rst_cmd;
      bus.wr && bus.addr == `MTAPT_A_RST && bus.wdata[0];
   endsequence
   sequence s_clear;
      s_rst_cmd or (bus.wr && bus.addr == `MTAPT_A_FCLR && bus.wdata[0]);
   endsequence

   a_rst_load_ofs: assert property (s_rst_cmd |=> s_q.cur == $past(s_q.ofs)) // RL5
      else $error("position not loaded with offset on reset command");
   // an undervoltage level seen beside the command sets the fault again
   a_rst_clr_turns: assert property (s_rst_cmd |=> s_q.turns == 16'h0000 && (!s_q.uvflt || $past(enc.uv))) // RL4
      else $error("turns or fault not cleared on reset command");
   a_ofs_range: assert property (wr_ofs && bus.wdata == 32'h80000000 |=> $stable(s_q.ofs)) // RL6
      else $error("offset accepted an out of range value");
   a_ofs_write: assert property (wr_ofs && ofs_ok |=> s_q.ofs == $past(bus.wdata)) // RL6
      else $error("offset write not taken at once");
   a_thr_range: assert property (bus.wr && bus.addr == `MTAPT_A_THR && bus.wdata > 32'h00000064
                                 |=> $stable(s_q.thr)) // RL12
      else $error("threshold accepted a value above limit");
   a_mask_defer: assert property (!pwr_up |=> $stable(s_q.bmask_act)) // RL17
      else $error("battery mask changed without power-up");
   a_bfail_hold: assert property (s_q.bfail && !(bus.wr && (bus.addr == `MTAPT_A_RST ||
                                  bus.addr == `MTAPT_A_FCLR)) |=> s_q.bfail) // RL15
      else $error("battery fault dropped without clear");
   a_bfail_masked: assert property (s_q.bmask_act && !s_q.bfail |=> !s_q.bfail) // RL11
      else $error("battery fault raised while masked");
   a_bfail_set: assert property (enc.connect && !s_q.bmask_act |=> s_q.bfail) // RL15
      else $error("battery fault not raised on connect");
   a_low_warn: assert property (!s_q.bmask_act && enc.mv < `MTAPT_LOW_MV ##1 !pwr_up
                                |-> s_q.lowwarn) // RL14
      else $error("low battery warning missing");
   a_clear_then: assert property (s_clear ##0 !enc.uv ##1 !enc.uv [*2] |-> !s_q.uvflt) // RL4
      else $error("undervoltage fault survived clear");
   a_irq_level: assert property (s_q.ists[`MTAPT_EV_BFAIL] && s_q.imsk[`MTAPT_EV_BFAIL]
                                 && !bus.wr |=> irq) // RL15
      else $error("interrupt low with unmasked status set");
endmodule : mtapt_top
`default_nettype wire

// file: testbench/mtapt_enc_model.sv
/*
 encoder model: single-turn samples, check error pulses and battery state.
 assumes the bench calls its tasks and shares clk with the tracker.
*/
`timescale 1ns/100ps
`default_nettype none
module mtapt_enc_model
   import mtapt_pkg::*;
(
   input  wire logic       clk,  // system clock
   output var  mtapt_enc_s enc   // samples and battery state to the tracker
);
   initial enc = '{mv: 12'he10, default: '0};

   task automatic sample(input logic [22:0] p);
      @(posedge clk) enc.valid <= 1'b1;
      enc.pos <= p;
      @(posedge clk) enc.valid <= 1'b0;
      // stale sample is not held once valid drops
      enc.pos <= ~p;
   endtask : sample

   task automatic err_pulse(input int n);
      repeat (n) begin
         @(posedge clk) enc.chk_err <= 1'b1;
         @(posedge clk) enc.chk_err <= 1'b0;
      end
   endtask : err_pulse

   task automatic connect();
      @(posedge clk) enc.connect <= 1'b1;
      @(posedge clk) enc.connect <= 1'b0;
   endtask : connect

   task automatic set_batt(input logic uv, input logic [11:0] mv, input logic opt);
      @(posedge clk) enc.uv <= uv;
      enc.mv <= mv;
      enc.optical <= opt;
   endtask : set_batt
endmodule : mtapt_enc_model
`default_nettype wire

// file: testbench/test_multi_turn_absolute_position_tracker.sv
/*
 bench of the position tracker: register port tasks and one task per scenario.
 assumes the encoder model and the tracker top are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "mtapt_consts.svh"
module test_multi_turn_absolute_position_tracker
   import mtapt_pkg::*;
();
   logic        clk = 1'b0;
   logic        srst;
   logic        pwr_up;
   mtapt_bus_s  bus;
   mtapt_enc_s  enc;
   logic [31:0] rd_data;
   logic        irq, comm_warn, batt_fail, batt_low;
   logic [31:0] v;
   int          bad_count = 0;
   int          comparisons = 0;
   int          cyc = 0;

   always #4 clk = ~clk;

   mtapt_enc_model enc_m (.clk(clk), .enc(enc));
   mtapt_top uut (.clk(clk), .srst(srst), .pwr_up(pwr_up), .bus(bus), .enc(enc), .rd_data(rd_data),
      .irq(irq), .comm_warn(comm_warn), .batt_fail(batt_fail), .batt_low(batt_low));

   task automatic conclude();
      if (bad_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk) bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk) bus.rd <= 1'b0;
      #1 d = rd_data;
   endtask : rd

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string m);
      logic [31:0] d;
      rd(a, d);
      chk(d, e, m);
   endtask : rc

   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick

   task automatic t_reset();
      rc(`MTAPT_A_BMASK, 32'h0, "mask rst");
      rc(`MTAPT_A_THR, 32'h14, "thr rst");
      rc(`MTAPT_A_OFS, 32'h0, "ofs rst");
      rc(`MTAPT_A_TURNS, 32'h0, "turns rst");
      rc(`MTAPT_A_CUR, 32'h0, "cur rst");
      rc(8'h40, 32'h0, "unmapped");
      chk({28'h0, irq, comm_warn, batt_fail, batt_low}, 32'h0, "outs rst");
   endtask : t_reset

   task automatic t_rerun();
      @(posedge clk) srst <= 1'b1;
      @(posedge clk) srst <= 1'b0;
      t_reset();
      rc(`MTAPT_A_STAT, 32'h80, "stat rst");
   endtask : t_rerun

   task automatic t_offset();
      wr(`MTAPT_A_OFS, 32'h80000000);
      rc(`MTAPT_A_OFS, 32'h0, "ofs low refuse");
      wr(`MTAPT_A_OFS, 32'h80000001);
      rc(`MTAPT_A_OFS, 32'h80000001, "ofs min");
      wr(`MTAPT_A_OFS, 32'h7fffffff);
      rc(`MTAPT_A_OFS, 32'h80000001, "ofs high refuse");
      wr(`MTAPT_A_OFS, 32'h7ffffffe);
      rc(`MTAPT_A_OFS, 32'h7ffffffe, "ofs max");
      wr(`MTAPT_A_OFS, 32'h100);
      wr(`MTAPT_A_RST, 32'h1);
      rc(`MTAPT_A_CUR, 32'h100, "cur load");
      rc(`MTAPT_A_RST, 32'h0, "rst reads 0");
   endtask : t_offset

   task automatic t_turns();
      enc_m.sample(23'h000010);
      enc_m.sample(23'h01fff0);
      rc(`MTAPT_A_TURNS, 32'hffff, "wrap back");
      rc(`MTAPT_A_CUR, 32'he0, "cur back");
      rc(`MTAPT_A_ST, 32'h1fff0, "st 17b");
      rc(`MTAPT_A_ABSLO, 32'hfffffff0, "abs lo");
      rc(`MTAPT_A_ABSHI, 32'h1, "abs hi");
      enc_m.sample(23'h7e0010);
      rc(`MTAPT_A_ST, 32'h10, "st masked");
      rc(`MTAPT_A_TURNS, 32'h0, "wrap fwd");
      rc(`MTAPT_A_CUR, 32'h100, "cur fwd");
      enc_m.sample(23'h01fff0);
      wr(`MTAPT_A_RST, 32'h1);
      rc(`MTAPT_A_TURNS, 32'h0, "turns clr");
      rc(`MTAPT_A_CUR, 32'h100, "cur after origin reset");
   endtask : t_turns

   task automatic t_comm();
      wr(`MTAPT_A_THR, 32'h65);
      rc(`MTAPT_A_THR, 32'h14, "thr refuse");
      wr(`MTAPT_A_THR, 32'h2);
      enc_m.err_pulse(2);
      tick();
      chk({31'h0, comm_warn}, 32'h0, "warn at thr");
      enc_m.err_pulse(1);
      tick();
      chk({31'h0, comm_warn}, 32'h1, "warn above");
      rd(`MTAPT_A_STAT, v);
      chk(v & 32'hff008, 32'h3008, "err count");
      wr(`MTAPT_A_THR, 32'h0);
      tick();
      chk({31'h0, comm_warn}, 32'h0, "thr zero");
      wr(`MTAPT_A_FCLR, 32'h1);
   endtask : t_comm

   task automatic t_batt();
      wr(`MTAPT_A_ISTS, 32'hf);
      wr(`MTAPT_A_IMSK, 32'h1);
      enc_m.connect();
      tick();
      chk({30'h0, batt_fail, irq}, 32'h3, "fault irq");
      wr(`MTAPT_A_ISTS, 32'h1);
      tick();
      chk({30'h0, batt_fail, irq}, 32'h2, "w1c held");
      wr(`MTAPT_A_FCLR, 32'h1);
      tick();
      chk({31'h0, batt_fail}, 32'h0, "fault clr");
      enc_m.connect();
      wr(`MTAPT_A_RST, 32'h1);
      tick();
      chk({31'h0, batt_fail}, 32'h0, "rst clr");
      enc_m.set_batt(1'b1, 12'hc1b, 1'b0);
      tick();
      tick();
      chk({31'h0, batt_low}, 32'h1, "low 3099");
      rd(`MTAPT_A_STAT, v);
      chk(v & 32'h2, 32'h2, "uv fault");
      enc_m.set_batt(1'b0, 12'hc1c, 1'b0);
      tick();
      tick();
      chk({31'h0, batt_low}, 32'h0, "low 3100");
      wr(`MTAPT_A_FCLR, 32'h1);
      wr(`MTAPT_A_BMASK, 32'h1);
      enc_m.connect();
      tick();
      chk({31'h0, batt_fail}, 32'h1, "mask waits");
      wr(`MTAPT_A_FCLR, 32'h1);
      @(posedge clk) pwr_up <= 1'b1;
      @(posedge clk) pwr_up <= 1'b0;
      enc_m.connect();
      enc_m.set_batt(1'b1, 12'h800, 1'b0);
      tick();
      tick();
      chk({30'h0, batt_fail, batt_low}, 32'h0, "masked");
      rd(`MTAPT_A_STAT, v);
      chk(v & 32'h43, 32'h40, "uv masked");
   endtask : t_batt

   task automatic t_optical();
      enc_m.set_batt(1'b0, 12'he10, 1'b1);
      enc_m.sample(23'h7fffff);
      rc(`MTAPT_A_ST, 32'h7fffff, "st 23b");
      rc(`MTAPT_A_TURNS, 32'hffff, "wrap optical");
      rc(`MTAPT_A_ABSLO, 32'hffffffff, "abs lo 23b");
      rc(`MTAPT_A_ABSHI, 32'h7f, "abs hi 23b");
   endtask : t_optical

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         conclude();
      end
   end

   initial begin
      srst = 1'b1;
      pwr_up = 1'b0;
      bus = '0;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_offset();
      t_turns();
      t_comm();
      t_batt();
      t_optical();
      t_rerun();
      conclude();
   end
endmodule : test_multi_turn_absolute_position_tracker
`default_nettype wire
